// file: stp_timer.v
// Single pulse output and input capture timer with AXI4-Lite registers
`timescale 1ns/1ps
`include "stp_consts.vh"

// Function
// - Run bit rising edge starts pulse
// - Trigger pin edge sets run bit
// - Run high: count and drive active
// - Run bit clear ends the pulse
// - Compare A match clears run bit
// - Compare A match sets A flag
// - Counter zeroed on run rise and on capture P match
// - Single pulse ignores P, clear, swap
// - Capture counting starts on run rise
// - Active capture edge latches count into A
// - Capture counter free runs until stopped
// - Compare P match zeroes counter, flags
// - Compare P zero: count to maximum
// - Edge select; 11 disables capture only
// - Capture drives no output pin
// - Edge codes rise, fall, both, off
// - Ten bit counter wraps after 3ff
module stp_timer
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // AXI4-Lite write channels
  input  wire [31:0] awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  // AXI4-Lite read channels
  input  wire [31:0] araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  // Timer pins
  input  wire        extClockTriggerPin,
  input  wire        captureInputPin,
  output reg         pulseOut,
  output reg         pulseOutEn,
  // Event pulses
  output reg         compareAEvent,
  output reg         comparePEvent
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        mergeBytes[i*8 +: 8] = strb[i] ? newVal[i*8 +: 8] : oldVal[i*8 +: 8];
    end
  endfunction

  function isRegOffset;
    input [7:0] addr;
    begin
      case (addr)
        `STP_OFF_CTRL0, `STP_OFF_CTRL1, `STP_OFF_COUNT,
        `STP_OFF_CMPA, `STP_OFF_CMPP, `STP_OFF_FLAGS:
          isRegOffset = 1'b1;
        default:
          isRegOffset = 1'b0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  wire              wrReq;
  wire [7:0]        wrAddr;
  wire [31:0]       wrData;
  wire [3:0]        wrStrb;
  wire [7:0]        rdAddr;
  reg  [31:0]       rdDataIn;

  reg               counterRunControl;
  reg  [1:0]        clockSelect;
  reg               modeSelectHi;
  reg               modeSelectLo;
  reg               pinFunctionHi;
  reg               pinFunctionLo;
  reg               outputInitialLevel;
  reg               outputInvert;
  reg               periodDutySwap;
  reg               clearSourceSelect;
  reg  [`STP_CW-1:0] compareAValue;
  reg  [`STP_CW-1:0] comparePValue;
  reg  [`STP_CW-1:0] count;
  reg               flagA;
  reg               flagP;

  reg               runPrev;
  reg               trigPrev;
  reg               capPrev;
  reg  [3:0]        prescale;

  reg               next_run;
  reg               tick;
  reg               capEdge;

  wire [1:0]        modeSel = {modeSelectHi, modeSelectLo};
  wire [1:0]        pinFunc = {pinFunctionHi, pinFunctionLo};
  wire              runRise = counterRunControl & ~runPrev;
  wire [`STP_CW-1:0] countInc = count + `STP_CNT_ONE;
  wire              wrCtrl0 = wrReq && wrAddr == `STP_OFF_CTRL0;
  wire              wrCtrl1 = wrReq && wrAddr == `STP_OFF_CTRL1;
  wire              wrFlags = wrReq && wrAddr == `STP_OFF_FLAGS;
  wire [31:0]       wrMerged = mergeBytes(rdDataIn, wrData, wrStrb);

  wire              spMode = modeSel == `STP_MODE_PWM && pinFunc == `STP_PF_SINGLE;
  wire              capMode = modeSel == `STP_MODE_CAP;

  // Advance and compare on new count
  wire              counting = counterRunControl & ~runRise & tick;
  wire              matchA = counting && countInc == compareAValue;
  wire              matchP = counting && comparePValue != `STP_CNT_ZERO &&
                             countInc == comparePValue;

  //////////////////////////////////////////////////////////////////////////////
  // Bus port

  stp_axil_port uPort
  (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .wrReq    (wrReq),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .wrStrb   (wrStrb),
    .wrOk     (isRegOffset(wrAddr)),
    .rdAddr   (rdAddr),
    .rdDataIn (rdDataIn),
    .rdOk     (isRegOffset(rdAddr))
  );

  // Read mux, also the old value for byte merging on writes
  always @*
  begin
    rdDataIn = 32'h00000000;
    case (wrReq ? wrAddr : rdAddr)
      `STP_OFF_CTRL0:
      begin
        rdDataIn[`STP_C0_RUN] = counterRunControl;
        rdDataIn[`STP_C0_CKS_HI:`STP_C0_CKS_LO] = clockSelect;
      end
      `STP_OFF_CTRL1:
        rdDataIn[7:0] = {modeSelectHi, modeSelectLo, pinFunctionHi,
                         pinFunctionLo, outputInitialLevel, outputInvert,
                         periodDutySwap, clearSourceSelect};
      `STP_OFF_COUNT:
        rdDataIn[`STP_CW-1:0] = count;
      `STP_OFF_CMPA:
        rdDataIn[`STP_CW-1:0] = compareAValue;
      `STP_OFF_CMPP:
        rdDataIn[`STP_CW-1:0] = comparePValue;
      `STP_OFF_FLAGS:
      begin
        rdDataIn[`STP_FL_A] = flagA;
        rdDataIn[`STP_FL_P] = flagP;
      end
      default:
        rdDataIn = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timer clock and pin edges

  always @*
  begin
    case (clockSelect)
      `STP_CKS_DIV4:  tick = prescale[1:0] == `STP_PRE_DIV4;
      `STP_CKS_DIV1:  tick = 1'b1;
      `STP_CKS_DIV16: tick = prescale == `STP_PRE_DIV16;
      `STP_CKS_EXT:   tick = extClockTriggerPin & ~trigPrev;
      default:        tick = 1'b0;
    endcase
  end

  always @*
  begin
    case (pinFunc)
      `STP_PF_RISE: capEdge = captureInputPin & ~capPrev;
      `STP_PF_FALL: capEdge = ~captureInputPin & capPrev;
      `STP_PF_BOTH: capEdge = captureInputPin ^ capPrev;
      `STP_PF_OFF:  capEdge = 1'b0;
      default:      capEdge = 1'b0;
    endcase
  end

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      prescale <= 4'h0;
      trigPrev <= 1'b0;
      capPrev  <= 1'b0;
      runPrev  <= 1'b0;
    end
    else
    begin
      prescale <= prescale + 4'h1;
      trigPrev <= extClockTriggerPin;
      capPrev  <= captureInputPin;
      runPrev  <= counterRunControl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Run control

  always @*
  begin
    next_run = counterRunControl;
    if (wrCtrl0)
      next_run = wrMerged[`STP_C0_RUN];
    if (spMode && extClockTriggerPin && !trigPrev)
      next_run = 1'b1;
    if (spMode && matchA)
      next_run = 1'b0;
  end

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      counterRunControl  <= 1'b0;
      clockSelect        <= `STP_CKS_DIV4;
      modeSelectHi       <= 1'b0;
      modeSelectLo       <= 1'b0;
      pinFunctionHi      <= 1'b0;
      pinFunctionLo      <= 1'b0;
      outputInitialLevel <= 1'b0;
      outputInvert       <= 1'b0;
      periodDutySwap     <= 1'b0;
      clearSourceSelect  <= 1'b0;
      comparePValue      <= `STP_CNT_ZERO;
    end
    else
    begin
      counterRunControl <= next_run;
      if (wrCtrl0)
        clockSelect <= wrMerged[`STP_C0_CKS_HI:`STP_C0_CKS_LO];
      if (wrCtrl1)
      begin
        modeSelectHi       <= wrMerged[`STP_C1_MODE_HI];
        modeSelectLo       <= wrMerged[`STP_C1_MODE_LO];
        pinFunctionHi      <= wrMerged[`STP_C1_PF_HI];
        pinFunctionLo      <= wrMerged[`STP_C1_PF_LO];
        outputInitialLevel <= wrMerged[`STP_C1_OC];
        outputInvert       <= wrMerged[`STP_C1_POL];
        periodDutySwap     <= wrMerged[`STP_C1_DPX];
        clearSourceSelect  <= wrMerged[`STP_C1_CCLR];
      end
      if (wrReq && wrAddr == `STP_OFF_CMPP)
        comparePValue <= wrMerged[`STP_CW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter, capture and flags

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      count         <= `STP_CNT_ZERO;
      compareAValue <= `STP_CNT_ZERO;
      flagA         <= 1'b0;
      flagP         <= 1'b0;
      compareAEvent <= 1'b0;
      comparePEvent <= 1'b0;
    end
    else
    begin
      if (runRise)
        count <= `STP_CNT_ZERO;
      else if (capMode && matchP)
        count <= `STP_CNT_ZERO;
      else if (counting)
        count <= countInc;

      if (capMode && capEdge)
        compareAValue <= count;
      else if (wrReq && wrAddr == `STP_OFF_CMPA)
        compareAValue <= wrMerged[`STP_CW-1:0];

      if ((spMode && matchA) || (capMode && capEdge))
        flagA <= 1'b1;
      else if (wrFlags && wrData[`STP_FL_A] && wrStrb[0])
        flagA <= 1'b0;
      // P flag only in capture mode
      if (capMode && matchP)
        flagP <= 1'b1;
      else if (wrFlags && wrData[`STP_FL_P] && wrStrb[0])
        flagP <= 1'b0;

      compareAEvent <= (spMode && matchA) || (capMode && capEdge);
      comparePEvent <= capMode && matchP;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pulse output

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pulseOut   <= 1'b0;
      pulseOutEn <= 1'b0;
    end
    else
    begin
      // Only single pulse drives the pin
      pulseOutEn <= spMode;
      if (spMode)
        pulseOut <= (next_run ? outputInitialLevel : ~outputInitialLevel)
                    ^ outputInvert;
      else
        pulseOut <= 1'b0;
    end
  end

endmodule

// file: stp_consts.vh
// Constants for the single pulse and capture timer block
`ifndef STP_CONSTS_VH
`define STP_CONSTS_VH

// Register byte offsets
`define STP_OFF_CTRL0   8'h00
`define STP_OFF_CTRL1   8'h04
`define STP_OFF_COUNT   8'h08
`define STP_OFF_CMPA    8'h0c
`define STP_OFF_CMPP    8'h10
`define STP_OFF_FLAGS   8'h14

// Control 0 field positions
`define STP_C0_RUN      3
`define STP_C0_CKS_HI   5
`define STP_C0_CKS_LO   4

// Control 1 field positions
`define STP_C1_MODE_HI  7
`define STP_C1_MODE_LO  6
`define STP_C1_PF_HI    5
`define STP_C1_PF_LO    4
`define STP_C1_OC       3
`define STP_C1_POL      2
`define STP_C1_DPX      1
`define STP_C1_CCLR     0

// Flag positions
`define STP_FL_A        0
`define STP_FL_P        1

// Mode select codes
`define STP_MODE_CMP    2'h0
`define STP_MODE_CAP    2'h1
`define STP_MODE_PWM    2'h2
`define STP_MODE_TMR    2'h3

// Pin function codes
`define STP_PF_RISE     2'h0
`define STP_PF_FALL     2'h1
`define STP_PF_BOTH     2'h2
`define STP_PF_OFF      2'h3
`define STP_PF_SINGLE   2'h3

// Timer clock select codes
`define STP_CKS_DIV4    2'h0
`define STP_CKS_DIV1    2'h1
`define STP_CKS_DIV16   2'h2
`define STP_CKS_EXT     2'h3

// Counter
`define STP_CW          10
`define STP_CNT_ZERO    10'h000
`define STP_CNT_ONE     10'h001
`define STP_PRE_DIV4    4'h3
`define STP_PRE_DIV16   4'hf

// Bus responses
`define STP_RESP_OKAY   2'h0
`define STP_RESP_SLVERR 2'h2

`endif

// file: stp_axil_port.v
// AXI4-Lite handshake front end for the timer registers
`timescale 1ns/1ps
`include "stp_consts.vh"

module stp_axil_port
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Write address and data
  input  wire [31:0] awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // Write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // Read address and data
  input  wire [31:0] araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Register file side
  output wire        wrReq,
  output reg  [7:0]  wrAddr,
  output reg  [31:0] wrData,
  output reg  [3:0]  wrStrb,
  input  wire        wrOk,
  output reg  [7:0]  rdAddr,
  input  wire [31:0] rdDataIn,
  input  wire        rdOk
);

  reg rdPend;

  // Both halves held, no response outstanding, read fetch not using the mux
  assign wrReq = ~awready & ~wready & ~bvalid & ~rdPend;

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `STP_RESP_OKAY;
      wrAddr  <= 8'h00;
      wrData  <= 32'h00000000;
      wrStrb  <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        // Out of range address lands on a hole, so the write has no effect
        wrAddr  <= (awaddr[31:8] == 24'h000000) ? awaddr[7:0] : 8'hff;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wrData <= wdata;
        wrStrb <= wstrb;
        wready <= 1'b0;
      end
      if (wrReq)
      begin
        bvalid  <= 1'b1;
        bresp   <= wrOk ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      arready <= 1'b1;
      rdPend  <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `STP_RESP_OKAY;
      rdAddr  <= 8'h00;
    end
    else
    begin
      if (arvalid && arready)
      begin
        rdAddr  <= araddr[7:0];
        arready <= 1'b0;
        rdPend  <= 1'b1;
      end
      if (rdPend)
      begin
        rdPend <= 1'b0;
        rvalid <= 1'b1;
        rdata  <= rdOk ? rdDataIn : 32'h00000000;
        rresp  <= rdOk ? `STP_RESP_OKAY : `STP_RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

// file: stp_timer_asserts.sv
// Bus and pulse checks for the single pulse and capture timer
`timescale 1ns/1ps
module stp_timer_asserts
(
  // Clock and reset
  input logic        ref_clk,
  input logic        reset,
  // Bus handshakes
  input logic        awvalid,
  input logic        awready,
  input logic        wvalid,
  input logic        wready,
  input logic [1:0]  bresp,
  input logic        bvalid,
  input logic        bready,
  input logic        arvalid,
  input logic        arready,
  input logic [31:0] rdata,
  input logic        rvalid,
  input logic        rready,
  // Pins and events
  input logic        pulseOut,
  input logic        pulseOutEn,
  input logic        compareAEvent,
  input logic        comparePEvent
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed before bready");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before rready");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read data late");
  a_read_busy: assert property (rvalid |-> !arready)
    else $error("read address open while data pending");
  a_pin_idle: assert property (!pulseOutEn |-> !pulseOut)
    else $error("pulse pin active while not driven");
  a_pulse_trail: assert property (
    $rose(compareAEvent) && pulseOutEn |-> pulseOut != $past(pulseOut))
    else $error("compare A match did not end the pulse");
  a_pulse_once: assert property (compareAEvent && pulseOutEn |=> !compareAEvent)
    else $error("second compare A event after a pulse");
  a_p_no_pulse: assert property (comparePEvent |-> !pulseOutEn)
    else $error("compare P event in single pulse");
  ////////////////////////////////////////////////////////////
  c_pulse: cover property (compareAEvent && pulseOutEn);
  c_p_match: cover property (comparePEvent);
  c_slverr: cover property (bvalid && bresp == 2'h2);
endmodule

// file: stp_pin_model.sv
// Pin partner: drives trigger and capture pins, measures pulse width
`timescale 1ns/1ps
module stp_pin_model
(
  // Clock and reset
  input  logic        ref_clk,
  input  logic        reset,
  // Requests from the bench
  input  logic        fireTrig,
  input  logic        capLevel,
  // Timer pins
  input  logic        pulseOut,
  input  logic        pulseOutEn,
  output logic        extClockTriggerPin,
  output logic        captureInputPin,
  // Width of the last pulse
  output logic [10:0] pulseWidth
);
  logic wasHigh;
  ////////////////////////////////////////////////////////////
  // Pin drive
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      extClockTriggerPin <= 1'h0;
      captureInputPin    <= 1'h0;
    end
    else
    begin
      extClockTriggerPin <= fireTrig;
      captureInputPin    <= capLevel;
    end
  end
  ////////////////////////////////////////////////////////////
  // Pulse width meter
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wasHigh    <= 1'h0;
      pulseWidth <= 11'h0;
    end
    else
    begin
      wasHigh <= pulseOutEn && pulseOut;
      if (pulseOutEn && pulseOut)
        pulseWidth <= wasHigh ? pulseWidth + 11'h1 : 11'h1;
    end
  end
endmodule

// file: stp_timer_tb.sv
// Self-checking bench for the single pulse and capture timer
`timescale 1ns/1ps
`include "stp_consts.vh"
module stp_timer_tb;
  logic        ref_clk = 1'h0;
  logic        reset = 1'h1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic        awready, wready, bvalid, arready, rvalid, pulseOut, pulseOutEn, evA, evP;
  logic        fireTrig = '0, capLevel = '0, extPin, capPin;
  logic [1:0]  bresp, rresp, lastResp;
  logic [10:0] pulseWidth;
  int          n_errors = 0, checked = 0, nCapt = 0, cyc = 0, pLast = 0, pGap = 0;
  int          capExp[4] = '{1, 1, 2, 0};
  int          capVal[4] = '{11, 21, 21, 256};

  stp_timer uut (.ref_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .extClockTriggerPin(extPin), .captureInputPin(capPin), .pulseOut, .pulseOutEn,
    .compareAEvent(evA), .comparePEvent(evP));
  stp_pin_model pins (.ref_clk, .reset, .fireTrig, .capLevel, .pulseOut, .pulseOutEn,
    .extClockTriggerPin(extPin), .captureInputPin(capPin), .pulseWidth);

  always #4 ref_clk = ~ref_clk;

  // Event counting and P match spacing
  always @(posedge ref_clk)
  begin
    cyc++;
    if (evA) nCapt++;
    if (evP)
    begin
      pGap = cyc - pLast;
      pLast = cyc;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge ref_clk);
    awaddr  <= {24'h0, a};
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      t++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end
    while (!bvalid && t < 40);
    bready <= 1'h0;
    chk("bresp", {bvalid, bresp}, {1'h1, er});
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    int t;
    t = 0;
    @(posedge ref_clk);
    araddr  <= {24'h0, a};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      t++;
      if (arvalid && arready) arvalid <= 1'h0;
    end
    while (!rvalid && t < 40);
    rready <= 1'h0;
    lastResp = rresp;
    chk(nm, rvalid ? rdata : '1, e);
  endtask

  task automatic wait_ev;
    int t;
    t = 0;
    while (!evA && t < 40)
    begin
      @(posedge ref_clk);
      t++;
    end
    chk("eventA", evA, 1'h1);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_errors++;
    tally_and_finish;
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    for (int i = 0; i < 6; i++)
      rdc("reset value", 8'(4 * i), 32'h0);
    rdc("unmapped read", 8'h18, 32'h0);
    chk("unmapped rresp", lastResp, `STP_RESP_SLVERR);
    wr(8'h18, 32'h1, `STP_RESP_SLVERR);
    $display("test registers done");
    // Single pulse with P, swap and clear source set
    wr(`STP_OFF_CMPP, 32'h2, `STP_RESP_OKAY);
    wr(`STP_OFF_CMPA, 32'h5, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL1, 32'hbb, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL0, 32'h18, `STP_RESP_OKAY);
    wait_ev();
    chk("pulse width", pulseWidth, 11'h6);
    chk("pulse idle", pulseOut, 1'h0);
    rdc("run cleared", `STP_OFF_CTRL0, 32'h10);
    rdc("count held", `STP_OFF_COUNT, 32'h5);
    rdc("flags", `STP_OFF_FLAGS, 32'h1);
    wr(`STP_OFF_FLAGS, 32'h3, `STP_RESP_OKAY);
    @(posedge ref_clk) fireTrig <= 1'h1;
    @(posedge ref_clk) fireTrig <= 1'h0;
    wait_ev();
    chk("trigger width", pulseWidth, 11'h6);
    wr(`STP_OFF_CMPA, 32'h100, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL0, 32'h18, `STP_RESP_OKAY);
    repeat (20) @(posedge ref_clk);
    wr(`STP_OFF_CTRL0, 32'h10, `STP_RESP_OKAY);
    chk("software stop", pulseOut, 1'h0);
    $display("test single pulse done");
    // Capture for every edge code
    wr(`STP_OFF_CMPP, 32'h0, `STP_RESP_OKAY);
    for (int pf = 0; pf < 4; pf++)
    begin
      wr(`STP_OFF_CMPA, 32'h100, `STP_RESP_OKAY);
      wr(`STP_OFF_FLAGS, 32'h3, `STP_RESP_OKAY);
      wr(`STP_OFF_CTRL1, 32'h40 | (32'(pf) << 4), `STP_RESP_OKAY);
      wr(`STP_OFF_CTRL0, 32'h18, `STP_RESP_OKAY);
      nCapt = 0;
      repeat (10) @(posedge ref_clk);
      capLevel <= 1'h1;
      repeat (10) @(posedge ref_clk);
      capLevel <= 1'h0;
      repeat (10) @(posedge ref_clk);
      chk("captures", 32'(nCapt), 32'(capExp[pf]));
      chk("pin driven", pulseOutEn, 1'h0);
      rdc("capture flag", `STP_OFF_FLAGS, 32'(pf != 3));
      rdc("capture count", `STP_OFF_CMPA, 32'(capVal[pf]));
      chk("capture range", 32'(rdata > 32'h5 && rdata < 32'h40), 32'(pf != 3));
      wr(`STP_OFF_CTRL0, 32'h10, `STP_RESP_OKAY);
    end
    $display("test capture done");
    // Compare P bound, then free run to the top
    wr(`STP_OFF_FLAGS, 32'h3, `STP_RESP_OKAY);
    wr(`STP_OFF_CMPP, 32'ha, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL1, 32'h70, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL0, 32'h18, `STP_RESP_OKAY);
    repeat (60) @(posedge ref_clk);
    chk("P period", 32'(pGap), 32'ha);
    rdc("P flag", `STP_OFF_FLAGS, 32'h2);
    wr(`STP_OFF_CTRL0, 32'h10, `STP_RESP_OKAY);
    wr(`STP_OFF_CMPP, 32'h0, `STP_RESP_OKAY);
    wr(`STP_OFF_FLAGS, 32'h3, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL0, 32'h18, `STP_RESP_OKAY);
    repeat (900) @(posedge ref_clk);
    rdc("count high", `STP_OFF_COUNT, 32'h386);
    chk("past old bound", 32'(rdata > 32'h300), 32'h1);
    repeat (200) @(posedge ref_clk);
    rdc("count wrapped", `STP_OFF_COUNT, 32'h52);
    chk("wrapped", 32'(rdata < 32'h100), 32'h1);
    rdc("no P flag", `STP_OFF_FLAGS, 32'h0);
    $display("test compare P done");
    // Slow and pin clocks, then inverted output levels
    wr(`STP_OFF_CTRL0, 32'h0, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL0, 32'h8, `STP_RESP_OKAY);
    repeat (38) @(posedge ref_clk);
    rdc("quarter rate", `STP_OFF_COUNT, 32'ha);
    wr(`STP_OFF_CTRL0, 32'h20, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL0, 32'h28, `STP_RESP_OKAY);
    repeat (158) @(posedge ref_clk);
    rdc("sixteenth rate", `STP_OFF_COUNT, 32'ha);
    wr(`STP_OFF_CTRL0, 32'h30, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL0, 32'h38, `STP_RESP_OKAY);
    repeat (5)
    begin
      @(posedge ref_clk) fireTrig <= 1'h1;
      @(posedge ref_clk) fireTrig <= 1'h0;
    end
    repeat (2) @(posedge ref_clk);
    rdc("pin rate", `STP_OFF_COUNT, 32'h5);
    wr(`STP_OFF_CTRL0, 32'h30, `STP_RESP_OKAY);
    wr(`STP_OFF_CTRL1, 32'hbc, `STP_RESP_OKAY);
    @(posedge ref_clk);
    chk("inverted idle", pulseOut, 1'h1);
    wr(`STP_OFF_CTRL0, 32'h18, `STP_RESP_OKAY);
    chk("inverted active", pulseOut, 1'h0);
    wr(`STP_OFF_CTRL0, 32'h10, `STP_RESP_OKAY);
    chk("inverted end", pulseOut, 1'h1);
    $display("test clocks and levels done");
    tally_and_finish;
  end
endmodule

bind stp_timer stp_timer_asserts sva (.ref_clk, .reset, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .pulseOut, .pulseOutEn, .compareAEvent, .comparePEvent);
